// ---- design/rmcd_map.vh ----
// Summary of operation
// - Bus clock runs at exactly half the clock generator primary output.
// - The 1 kHz low-power clock is selectable for watchdog and real-time counter.
// - Debug tools may select the fast debug clock for the debug controller.
// - External reference clock feeds the real-time counter and the converter alternate clock.
// - Internal reference clock is selectable for the real-time counter.
// - Fixed-frequency clock is selectable as counting clock for both timers.
// - Each timer accepts its own external clock input pin.
// - After any reset the device runs from the internal generated clock.
// - Each reset source drives the reset pin low for 68 system clock cycles.
// - Reset cause is decoded and recorded in the reset cause register.
// - An external low on the reset pin forces reset and is a source.
// - During reset the shared debug pin is only a mode-select input.
// - After reset release the shared pin becomes the debug communication pin.
// - Pin high at reset release selects normal operating mode.
// - Pin held low at reset release selects active background debug mode.
// - Each debug bit time lasts 16 debug controller clock cycles.
// - Debug controller clock may run faster than the bus clock when the fast debug clock is selected.
// - Debug pin is pseudo open-drain with short driven-high speed-up pulses.
`ifndef RMCD_MAP_VH
`define RMCD_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define RMCD_REG_CAUSE     12'h000
`define RMCD_REG_CLKSEL    12'h004
`define RMCD_REG_MODE      12'h008
`define RMCD_REG_SWRST     12'h00C
`define RMCD_REG_IRQ_STAT  12'h010
`define RMCD_REG_IRQ_MASK  12'h014

// ****************************************
// Reset cause bits
// ****************************************
`define RMCD_CAUSE_POR     0
`define RMCD_CAUSE_PIN     1
`define RMCD_CAUSE_WDOG    2
`define RMCD_CAUSE_LVD     3
`define RMCD_CAUSE_ILOP    4
`define RMCD_CAUSE_ILAD    5
`define RMCD_CAUSE_SW      6
`define RMCD_CAUSE_W       7

// ****************************************
// Clock select fields
// ****************************************
`define RMCD_SEL_WDOG      0
`define RMCD_SEL_RTC_LO    1
`define RMCD_SEL_RTC_HI    2
`define RMCD_SEL_T1_LO     3
`define RMCD_SEL_T1_HI     4
`define RMCD_SEL_T2_LO     5
`define RMCD_SEL_T2_HI     6
`define RMCD_SEL_ADC       7
`define RMCD_SEL_DBG       8
`define RMCD_CLKSEL_W      9
`define RMCD_CLKSEL_RST    9'h000

// Interrupt status bits
`define RMCD_IRQ_RESET     0
`define RMCD_IRQ_PINACT    1
`define RMCD_IRQ_W         2

// ****************************************
// Timing
// ****************************************
`define RMCD_STRETCH_BUS_CYC 34
// Stretch in system clocks, at least four per bus cycle; sized to the counter width
`define RMCD_STRETCH_CNT     7'h44
`define RMCD_CNT_W           7
`define RMCD_DBG_BIT_CYC     16
`define RMCD_SPEEDUP_CYC     1
`define RMCD_ID_VALUE        32'h00000000

`endif

// ---- design/rmcd_top.v ----
`timescale 1ns/1ps
`include "rmcd_map.vh"

module rmcd_top (
   // Clock and reset
   input  wire        clock,
   input  wire        nrst,
   // AXI4-Lite write address and data
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Clock sources
   input  wire        clock_gen_primary_out,
   input  wire        low_power_1khz_osc,
   input  wire        clock_gen_debug_fast_clock,
   input  wire        external_ref_clock_out,
   input  wire        internal_ref_clock_out,
   input  wire        fixed_freq_clock,
   input  wire        timer1_ext_clock_in,
   input  wire        timer2_ext_clock_in,
   // Clock generator control
   output reg         clock_gen_use_internal,
   // Distributed clock enables
   output reg         system_bus_clock,
   output reg         watchdog_clock,
   output reg         rtc_clock,
   output reg         timer1_clock,
   output reg         timer2_clock,
   output reg         adc_alt_clock,
   output reg         debug_ctrl_clock,
   // Internal reset sources
   input  wire        por_event,
   input  wire        watchdog_reset_req,
   input  wire        low_voltage_reset_req,
   input  wire        illegal_opcode_req,
   input  wire        illegal_address_req,
   // Reset pin, open drain
   input  wire        reset_pin_in,
   output wire        reset_pin_out,
   output wire        reset_pin_oe,
   output wire        system_reset_n,
   // Shared debug / mode-select pin
   input  wire        debug_modeselect_pin_in,
   output wire        debug_modeselect_pin_out,
   output wire        debug_modeselect_pin_oe,
   input  wire        debug_tx_bit,
   input  wire        debug_tx_start,
   output reg         debug_tx_busy,
   output reg         debug_rx_level,
   output reg         background_mode,
   // Interrupt
   output wire        irq
);

   // ****************************************
   // Reset stretch and cause
   // ****************************************
   reg [`RMCD_CNT_W-1:0]   stretch_cnt;
   reg [`RMCD_CAUSE_W-1:0] reset_cause_register;
   reg                     sw_reset_req;
   reg                     in_reset;
   reg                     pin_seen_low;
   reg                     mode_latched;
   wire                    any_internal;
   wire                    pin_low;
   wire [`RMCD_CAUSE_W-1:0] new_cause;

   // Pin low while out of reset means an external party pulls it
   assign pin_low = ~reset_pin_in & ~in_reset;
   assign any_internal = por_event | watchdog_reset_req | low_voltage_reset_req |
                         illegal_opcode_req | illegal_address_req | sw_reset_req;

   assign new_cause = {sw_reset_req, illegal_address_req, illegal_opcode_req,
                       low_voltage_reset_req, watchdog_reset_req, pin_low, por_event};

   // Stretch counts system clocks: at least four per bus cycle
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stretch_cnt          <= `RMCD_CNT_W'h00;
         in_reset             <= 1'b1;
         reset_cause_register <= 7'h01;
      end else if (any_internal || pin_low) begin
         stretch_cnt          <= `RMCD_STRETCH_CNT;
         in_reset             <= 1'b1;
         reset_cause_register <= new_cause;
      end else if (stretch_cnt != `RMCD_CNT_W'h00) begin
         stretch_cnt <= stretch_cnt - `RMCD_CNT_W'h01;
      end else if (reset_pin_in) begin
         // Hold reset until the pin is seen released by outside pulls too
         in_reset <= 1'b0;
      end
   end

   assign reset_pin_out  = 1'b0;
   assign reset_pin_oe   = (stretch_cnt != `RMCD_CNT_W'h00);
   assign system_reset_n = ~in_reset;

   // ****************************************
   // Mode select and debug pin
   // ****************************************
   reg       in_reset_d;
   reg [3:0] bit_cnt;
   reg       speedup;

   // latch mode once at reset release
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         in_reset_d      <= 1'b1;
         background_mode <= 1'b0;
         mode_latched    <= 1'b0;
      end else begin
         in_reset_d <= in_reset;
         if (in_reset) begin
            mode_latched <= 1'b0;
         end else if (in_reset_d && !mode_latched) begin
            background_mode <= ~debug_modeselect_pin_in;
            mode_latched    <= 1'b1;
         end
      end
   end

   // bit timer with open-drain low and short high pulse
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bit_cnt        <= 4'h0;
         debug_tx_busy  <= 1'b0;
         speedup        <= 1'b0;
         debug_rx_level <= 1'b1;
      end else begin
         debug_rx_level <= debug_modeselect_pin_in;
         speedup        <= 1'b0;
         if (in_reset) begin
            debug_tx_busy <= 1'b0;
            bit_cnt       <= 4'h0;
         end else if (debug_ctrl_clock) begin
            if (!debug_tx_busy && debug_tx_start) begin
               debug_tx_busy <= 1'b1;
               bit_cnt       <= 4'h0;
            end else if (debug_tx_busy) begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'hF) begin
                  debug_tx_busy <= 1'b0;
                  speedup       <= 1'b1;
               end else if (bit_cnt == 4'h3 && debug_tx_bit) begin
                  speedup <= 1'b1;
               end
            end
         end
      end
   end

   // pin serves debug only out of reset
   wire drive_low = debug_tx_busy & (bit_cnt < 4'h4 | ~debug_tx_bit) & ~speedup;
   assign debug_modeselect_pin_out = speedup;
   assign debug_modeselect_pin_oe  = ~in_reset & (drive_low | speedup);

   // ****************************************
   // Clock distribution
   // ****************************************
   reg [`RMCD_CLKSEL_W-1:0] clksel;
   reg                      prim_d;

   // Pick one of four clock source levels; outputs register the level, not an edge
   function sel4;
      input [1:0] s;
      input       a;
      input       b;
      input       c;
      input       d;
      begin
         sel4 = (s == 2'b00) ? a : (s == 2'b01) ? b : (s == 2'b10) ? c : d;
      end
   endfunction

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         prim_d                 <= 1'b0;
         system_bus_clock       <= 1'b0;
         watchdog_clock         <= 1'b0;
         rtc_clock              <= 1'b0;
         timer1_clock           <= 1'b0;
         timer2_clock           <= 1'b0;
         adc_alt_clock          <= 1'b0;
         debug_ctrl_clock       <= 1'b0;
         clock_gen_use_internal <= 1'b1;
      end else begin
         prim_d <= clock_gen_primary_out;
         // bus toggles on each primary rising edge: half frequency
         if (clock_gen_primary_out && !prim_d)
            system_bus_clock <= ~system_bus_clock;
         if (in_reset)
            clock_gen_use_internal <= 1'b1;
         watchdog_clock <= clksel[`RMCD_SEL_WDOG] ? low_power_1khz_osc : system_bus_clock;
         rtc_clock <= sel4(clksel[`RMCD_SEL_RTC_HI:`RMCD_SEL_RTC_LO], low_power_1khz_osc,
                           external_ref_clock_out, internal_ref_clock_out, 1'b0);
         timer1_clock <= sel4(clksel[`RMCD_SEL_T1_HI:`RMCD_SEL_T1_LO], system_bus_clock,
                              fixed_freq_clock, timer1_ext_clock_in, 1'b0);
         timer2_clock <= sel4(clksel[`RMCD_SEL_T2_HI:`RMCD_SEL_T2_LO], system_bus_clock,
                              fixed_freq_clock, timer2_ext_clock_in, 1'b0);
         adc_alt_clock <= clksel[`RMCD_SEL_ADC] ? external_ref_clock_out : system_bus_clock;
         debug_ctrl_clock <= clksel[`RMCD_SEL_DBG] ? clock_gen_debug_fast_clock
                                                     : system_bus_clock;
      end
   end

   // ****************************************
   // Register bus and interrupts
   // ****************************************
   reg [`RMCD_IRQ_W-1:0] irq_stat;
   reg [`RMCD_IRQ_W-1:0] irq_mask;
   reg                   aw_held;
   reg                   w_held;
   reg [11:0]            aw_addr;
   reg [31:0]            w_data;
   wire                  do_write;
   wire [1:0]            ev;

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_write      = aw_held & w_held & ~s_axi_bvalid;
   assign ev            = {pin_low, in_reset & ~in_reset_d};
   assign irq           = |(irq_stat & irq_mask);

   // Write side: address and data may come in either order
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 12'h000;
         w_data       <= 32'h00000000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         clksel       <= `RMCD_CLKSEL_RST;
         irq_mask     <= 2'h0;
         irq_stat     <= 2'h0;
         sw_reset_req <= 1'b0;
      end else begin
         sw_reset_req <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // Set wins over a simultaneous clear
         irq_stat <= irq_stat | ev;
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            if (aw_addr == `RMCD_REG_CLKSEL)
               clksel <= w_data[`RMCD_CLKSEL_W-1:0];
            else if (aw_addr == `RMCD_REG_SWRST)
               sw_reset_req <= w_data[0];
            else if (aw_addr == `RMCD_REG_IRQ_STAT)
               irq_stat <= (irq_stat & ~w_data[1:0]) | ev;
            else if (aw_addr == `RMCD_REG_IRQ_MASK)
               irq_mask <= w_data[1:0];
            else if (aw_addr != `RMCD_REG_CAUSE && aw_addr != `RMCD_REG_MODE)
               s_axi_bresp <= 2'b10;
         end
      end
   end

   // Read side: one cycle after the address is taken
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         s_axi_rdata  <= 32'h00000000;
         if (s_axi_araddr == `RMCD_REG_CAUSE)
            s_axi_rdata <= {25'h0, reset_cause_register};
         else if (s_axi_araddr == `RMCD_REG_CLKSEL)
            s_axi_rdata <= {23'h0, clksel};
         else if (s_axi_araddr == `RMCD_REG_MODE)
            s_axi_rdata <= {30'h0, mode_latched, background_mode};
         else if (s_axi_araddr == `RMCD_REG_SWRST)
            s_axi_rdata <= 32'h00000000;
         else if (s_axi_araddr == `RMCD_REG_IRQ_STAT)
            s_axi_rdata <= {30'h0, irq_stat};
         else if (s_axi_araddr == `RMCD_REG_IRQ_MASK)
            s_axi_rdata <= {30'h0, irq_mask};
         else
            s_axi_rresp <= 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ---- sim/rmcd_host.sv ----
`timescale 1ns/1ps
// ******************************
// Debug host and reset switch
// ******************************
module rmcd_host (
   // Commands from the bench
   input  logic hold_reset,
   input  logic hold_mode,
   // Device pin drivers
   input  logic reset_pin_oe,
   input  logic reset_pin_out,
   input  logic dbg_oe,
   input  logic dbg_out,
   // Resolved pin levels
   output logic reset_pin_in,
   output logic debug_modeselect_pin_in
);
   // pin pulled low
   // Both pins have pull-ups, so a released line reads high
   assign reset_pin_in = !hold_reset && (reset_pin_oe ? reset_pin_out : 1'b1);
   // host holds low
   // Host only sinks; the device's speed-up pulse wins only when host lets go
   assign debug_modeselect_pin_in = !hold_mode && (dbg_oe ? dbg_out : 1'b1);
endmodule

// ---- sim/rmcd_props.sv ----
`timescale 1ns/1ps
// ********************
// Checker on top ports
// ********************
module rmcd_props (
   // Clock and reset
   input logic clock,
   input logic nrst,
   // Clocking and reset pins
   input logic clock_gen_primary_out,
   input logic system_bus_clock,
   input logic clock_gen_use_internal,
   input logic watchdog_reset_req,
   input logic reset_pin_in,
   input logic reset_pin_oe,
   input logic system_reset_n,
   // Shared debug pin
   input logic debug_modeselect_pin_in,
   input logic debug_modeselect_pin_out,
   input logic debug_modeselect_pin_oe,
   input logic debug_rx_level,
   input logic background_mode,
   input logic irq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   int unsigned oe_cnt;

   // Length of the running stretch, so a wrong terminal count shows up
   always @(posedge clock or negedge nrst) begin
      if (!nrst)
         oe_cnt <= 0;
      else if (reset_pin_oe)
         oe_cnt <= oe_cnt + 1;
      else
         oe_cnt <= 0;
   end

   bus_clk_rise_a: assert property (
      $rose(clock_gen_primary_out) |-> ##[1:3] $changed(system_bus_clock))
      else $error("bus clock missed a primary clock rise");
   bus_clk_hold_a: assert property (
      !$rose(clock_gen_primary_out) |=> $stable(system_bus_clock))
      else $error("bus clock moved without a primary clock rise");
   stretch_len_a: assert property (
      $fell(reset_pin_oe) |-> oe_cnt == 68)
      else $error("reset pin stretch has wrong length");
   req_start_a: assert property (
      $rose(watchdog_reset_req) && !reset_pin_oe |=> reset_pin_oe && !system_reset_n)
      else $error("watchdog request did not start a reset");
   pin_force_a: assert property (
      !reset_pin_in && !reset_pin_oe && system_reset_n |=> reset_pin_oe && !system_reset_n)
      else $error("external low on reset pin ignored");
   int_clk_a: assert property (
      !system_reset_n && !$past(system_reset_n) |-> clock_gen_use_internal)
      else $error("internal clock not chosen in reset");
   sel_input_a: assert property (
      !system_reset_n && !$past(system_reset_n) |-> !debug_modeselect_pin_oe)
      else $error("debug pin driven during reset");
   rx_follow_a: assert property (
      system_reset_n && $past(system_reset_n)
      |-> debug_rx_level == $past(debug_modeselect_pin_in))
      else $error("debug receive level does not follow pin");
   mode_hold_a: assert property (
      system_reset_n && $past(system_reset_n) && $past(system_reset_n, 2)
      |-> $stable(background_mode))
      else $error("mode changed outside reset");
   pin_drive_a: assert property (
      debug_modeselect_pin_out |-> debug_modeselect_pin_oe)
      else $error("debug pin high level without drive");

   cover property ($fell(reset_pin_oe));
   cover property ($rose(background_mode));
   cover property ($rose(irq));
endmodule

bind rmcd_top rmcd_props u_props (.clock, .nrst, .clock_gen_primary_out, .system_bus_clock,
   .clock_gen_use_internal, .watchdog_reset_req, .reset_pin_in, .reset_pin_oe,
   .system_reset_n, .debug_modeselect_pin_in, .debug_modeselect_pin_out,
   .debug_modeselect_pin_oe, .debug_rx_level, .background_mode, .irq);

// ---- sim/rmcd_top_tb.sv ----
`timescale 1ns/1ps
`include "rmcd_map.vh"
module rmcd_top_tb;
   // ********************
   // Signals
   // ********************
   logic        clock = 0, nrst = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat, rd;
   logic [1:0]  bresp, rresp, rs;
   logic        awr, wr_rdy, bv, arr, rv, bus_clk, use_int, rst_in, rst_out, rst_oe;
   logic        srn, ms_in, ms_out, ms_oe, tx_busy, rx_lvl, bg, irq;
   logic [6:0]  src = 0, cur = 0, prev;
   logic [5:0]  dclk;
   logic [4:0]  req = 0;
   logic [1:0]  pcnt = 0;
   logic        tx_bit = 0, tx_go = 0, hold_rst = 0, hold_ms = 0;
   logic [8:0]  cfg [3] = '{9'h1C9, 9'h1B3, 9'h1AD};
   int          n_mismatch = 0, checks_done = 0, oe_run = 0, oe_last = 0;
   int          i, c, k, b0, l0, b1, l1;

   rmcd_top dut (.clock(clock), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .clock_gen_primary_out(pcnt[1]), .low_power_1khz_osc(src[0]),
      .clock_gen_debug_fast_clock(src[1]), .external_ref_clock_out(src[2]),
      .internal_ref_clock_out(src[3]), .fixed_freq_clock(src[4]),
      .timer1_ext_clock_in(src[5]), .timer2_ext_clock_in(src[6]),
      .clock_gen_use_internal(use_int), .system_bus_clock(bus_clk), .watchdog_clock(dclk[0]),
      .rtc_clock(dclk[1]), .timer1_clock(dclk[2]), .timer2_clock(dclk[3]),
      .adc_alt_clock(dclk[4]), .debug_ctrl_clock(dclk[5]), .por_event(req[0]),
      .watchdog_reset_req(req[1]), .low_voltage_reset_req(req[2]),
      .illegal_opcode_req(req[3]), .illegal_address_req(req[4]), .reset_pin_in(rst_in),
      .reset_pin_out(rst_out), .reset_pin_oe(rst_oe), .system_reset_n(srn),
      .debug_modeselect_pin_in(ms_in), .debug_modeselect_pin_out(ms_out),
      .debug_modeselect_pin_oe(ms_oe), .debug_tx_bit(tx_bit), .debug_tx_start(tx_go),
      .debug_tx_busy(tx_busy), .debug_rx_level(rx_lvl), .background_mode(bg), .irq(irq));

   rmcd_host u_host (.hold_reset(hold_rst), .hold_mode(hold_ms), .reset_pin_oe(rst_oe),
      .reset_pin_out(rst_out), .dbg_oe(ms_oe), .dbg_out(ms_out), .reset_pin_in(rst_in),
      .debug_modeselect_pin_in(ms_in));

   // Clock, and a primary clock at a quarter of it
   always #10 clock = ~clock;
   always @(posedge clock) pcnt <= pcnt + 2'h1;

   // Measure each stretch on the reset pin
   always @(negedge clock) begin
      if (rst_oe === 1'b1)
         oe_run++;
      else if (oe_run != 0) begin
         oe_last = oe_run;
         oe_run = 0;
      end
   end

   // ********************
   // Tasks
   // ********************
   function automatic logic [5:0] exp_clk(input logic [8:0] s, input logic [6:0] v);
      exp_clk[0] = v[0];
      exp_clk[1] = s[2:1] == 2'h1 ? v[2] : (s[2:1] == 2'h2 ? v[3] : v[0]);
      exp_clk[2] = s[4:3] == 2'h1 ? v[4] : v[5];
      exp_clk[3] = s[6:5] == 2'h1 ? v[4] : v[6];
      exp_clk[4] = v[2];
      exp_clk[5] = v[1];
   endfunction

   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int t = 0;
      @(posedge clock);
      awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
      do begin
         @(posedge clock);
         if (awr) awv <= 0;
         if (wr_rdy) wv <= 0;
         t++;
      end while (!bv && t < 200);
      rs = bresp;
      bry <= 0;
   endtask

   task automatic rdr(input logic [11:0] a);
      int t = 0;
      @(posedge clock);
      ara <= a; arv <= 1; rry <= 1;
      do begin
         @(posedge clock);
         if (arr) arv <= 0;
         t++;
      end while (!rv && t < 200);
      rd = rdat; rs = rresp;
      rry <= 0;
   endtask

   // Start a reset of cause k, wait it out, then check length and cause
   task automatic fire(input int k);
      int t;
      oe_last = 0;
      if (k == 6) wr(`RMCD_REG_SWRST, 32'h1);
      else begin
         @(posedge clock);
         if (k == 1) hold_rst <= 1;
         else req[k == 0 ? 0 : k - 1] <= 1;
         repeat (k == 1 ? 3 : 1) @(posedge clock);
         hold_rst <= 0; req <= 0;
      end
      for (t = 0; t < 400 && !(oe_last != 0 && srn === 1'b1); t++) @(posedge clock);
      cmp("stretch length", 68, oe_last);
      rdr(`RMCD_REG_CAUSE);
      cmp("reset cause", 32'h1 << k, rd);
   endtask

   task automatic tx(input logic b, output int busy, output int low);
      int t = 0;
      busy = 0; low = 0;
      @(posedge clock);
      tx_bit <= b; tx_go <= 1;
      @(posedge clock);
      tx_go <= 0;
      do begin
         @(negedge clock);
         if (tx_busy === 1'b1) busy++;
         if (tx_busy === 1'b1 && ms_in === 1'b0) low++;
         t++;
      end while ((tx_busy === 1'b1 || t < 3) && t < 100);
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ********************
   // Tests
   // ********************
   initial begin
      void'($urandom(52338));
      repeat (6) @(posedge clock);
      nrst <= 1;
      for (i = 0; i < 100 && srn !== 1'b1; i++) @(posedge clock);
      rdr(`RMCD_REG_CAUSE);
      cmp("cause after power up", 32'h1, rd);
      cmp("mode with pin released", 0, bg);
      rdr(`RMCD_REG_CLKSEL);
      cmp("clock select reset", `RMCD_CLKSEL_RST, rd);
      wr(`RMCD_REG_IRQ_MASK, 32'h1);
      for (k = 0; k < 7; k++) fire(k);
      rdr(`RMCD_REG_IRQ_STAT);
      cmp("irq status", 32'h3, rd);
      cmp("irq unmasked", 1, irq);
      wr(`RMCD_REG_IRQ_MASK, 32'h0);
      cmp("irq masked", 0, irq);
      wr(`RMCD_REG_IRQ_MASK, 32'h1);
      wr(`RMCD_REG_IRQ_STAT, 32'h3);
      cmp("irq cleared", 0, irq);
      rdr(12'h100);
      cmp("unmapped response", 2, rs);
      // Host holds the mode pin low across release, then wiggles it
      hold_ms <= 1;
      fire(2);
      repeat (4) @(posedge clock);
      hold_ms <= 0;
      cmp("debug mode entered", 1, bg);
      repeat (6) @(posedge clock) hold_ms <= ~hold_ms;
      repeat (3) @(posedge clock);
      cmp("debug mode held", 1, bg);
      fire(2);
      cmp("normal mode entered", 0, bg);
      // Random source levels through three selections, none picking the bus clock
      for (c = 0; c < 3; c++) begin
         wr(`RMCD_REG_CLKSEL, {23'h0, cfg[c]});
         for (i = 0; i < 40; i++) begin
            @(posedge clock);
            prev = cur;
            cur = 7'($urandom);
            src <= cur;
            @(negedge clock);
            if (i > 0) cmp("selected clocks", exp_clk(cfg[c], prev), dclk);
         end
      end
      k = 0;
      @(negedge clock);
      for (i = 0; i < 80; i++) begin
         prev[0] = bus_clk;
         @(negedge clock);
         if (bus_clk !== prev[0]) k++;
      end
      cmp("bus clock toggles", 20, k);
      // Fast debug clock held high: one enable per system clock
      src <= 7'h7F;
      tx(1'b1, b1, l1);
      tx(1'b0, b0, l0);
      cmp("bit time one", 16, b1);
      cmp("bit time zero", 16, b0);
      cmp("zero held low longer", 1, l0 > l1);
      wrap_up;
   end

   // Cut a hang short
   initial begin
      #(20 * 40000);
      n_mismatch++;
      wrap_up;
   end
endmodule
